// file: rtl/vdc_pkg.sv
// shared constants and types for the dac setting block with eeprom shadow
// assumes a system clock of 50 MHz and a slave-only two-wire bus

package vdc_pkg;

    // ------------------------------------------------------------------
    // setting code and bus framing
    // ------------------------------------------------------------------
    localparam int          CODE_W      = 7;
    localparam int          STEPS_W     = 8;
    localparam logic [7:0]  ADDR_BYTE   = 8'h9E;
    localparam logic [3:0]  BIT_LAST    = 4'h7;
    localparam logic [3:0]  BIT_ACK     = 4'h8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0]  SETTING_RST = 7'h00;
    // content of a never-programmed cell
    localparam logic [CODE_W-1:0]  EE_ERASED   = 7'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int  CLK_MHZ     = 50;
    localparam int  STARTUP_US  = 30;
    localparam int  PROG_MS     = 200;
    localparam int  STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int  PROG_CYC    = PROG_MS * 1000 * CLK_MHZ;
    localparam int  TIMER_W     = 24;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              store;
        logic [CODE_W-1:0] code;
    } vdc_word_s;

    typedef enum logic [1:0] {
        VDC_LOAD = 2'b00,
        VDC_RUN  = 2'b01,
        VDC_PROG = 2'b11
    } vdc_state_e;

    typedef enum logic [1:0] {
        VDC_IDLE = 2'b00,
        VDC_ADDR = 2'b01,
        VDC_DATA = 2'b11,
        VDC_SKIP = 2'b10
    } vdc_phase_e;

endpackage

// file: rtl/vdc_link.sv
// bus-facing half: start detection, byte shifting, acknowledge drive
// assumes the master clocks no faster than 400 kHz and sends a
// two-byte write frame (address byte, then code plus store bit)
`timescale 1ns/1ps

module vdc_link (
    input  wire logic          rst_n,
    input  wire logic          scl,
    input  wire logic          sclSw,
    input  wire logic          sdaIn,
    input  wire logic          wpN,
    output logic               sdaOe,
    output vdc_pkg::vdc_word_s linkWord,
    output logic               wordToggle
);

    // ------------------------------------------------------------------
    // bus clock selection
    // ------------------------------------------------------------------
    wire logic busClk;
    // R06 switched clock
    // with protect released the two clock pins are shorted, so both
    // must be high for the line to read high
    assign busClk = wpN ? (scl & sclSw) : scl;

    // ------------------------------------------------------------------
    // start detection: data falling while the clock is high
    // ------------------------------------------------------------------
    logic startTog;
    logic startSeen;

    always_ff @(negedge sdaIn or negedge rst_n) begin
        if (!rst_n) begin
            startTog <= 1'b0;
        end else if (busClk) begin
            // any number of starts before the next falling clock edge
            // counts as one, so stray data edges cannot cancel a start
            startTog <= ~startSeen;
        end
    end

    // ------------------------------------------------------------------
    // bit sampling on the rising clock edge
    // ------------------------------------------------------------------
    logic [7:0] shiftReg;

    always_ff @(posedge busClk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= 8'h00;
        end else begin
            shiftReg <= {shiftReg[6:0], sdaIn};
        end
    end

    // ------------------------------------------------------------------
    // framing, updated on the falling clock edge
    // ------------------------------------------------------------------
    vdc_pkg::vdc_phase_e phase;
    vdc_pkg::vdc_phase_e next_phase;
    logic [3:0]          bitCnt;
    wire logic [3:0]     next_bitCnt;
    wire logic           startNow;
    wire logic           byteEnd;
    wire logic           ackEnd;
    wire logic           addrHit;
    wire logic           addrMiss;
    wire logic           wordDone;
    wire logic           next_sdaOe;

    assign startNow = startTog ^ startSeen;
    assign byteEnd  = (bitCnt == vdc_pkg::BIT_LAST);
    assign ackEnd   = (bitCnt == vdc_pkg::BIT_ACK);
    // R09 own address
    assign addrHit  = (phase == vdc_pkg::VDC_ADDR) && byteEnd
                   && (shiftReg == vdc_pkg::ADDR_BYTE);
    assign addrMiss = (phase == vdc_pkg::VDC_ADDR) && byteEnd
                   && (shiftReg != vdc_pkg::ADDR_BYTE);
    assign wordDone = (phase == vdc_pkg::VDC_DATA) && byteEnd;
    assign next_sdaOe = !startNow && (addrHit || wordDone);
    assign next_bitCnt = (startNow || ackEnd) ? 4'h0 : bitCnt + 4'h1;

    always_comb begin
        next_phase = phase;
        if (startNow) begin
            next_phase = vdc_pkg::VDC_ADDR;
        end else if (addrMiss) begin
            next_phase = vdc_pkg::VDC_SKIP;
        end else if (ackEnd && phase == vdc_pkg::VDC_ADDR) begin
            next_phase = vdc_pkg::VDC_DATA;
        end else if (ackEnd && phase == vdc_pkg::VDC_DATA) begin
            next_phase = vdc_pkg::VDC_IDLE;
        end
    end

    always_ff @(negedge busClk or negedge rst_n) begin
        if (!rst_n) begin
            phase      <= vdc_pkg::VDC_IDLE;
            bitCnt     <= 4'h0;
            startSeen  <= 1'b0;
            sdaOe      <= 1'b0;
            linkWord   <= '0;
            wordToggle <= 1'b0;
        end else begin
            phase     <= next_phase;
            bitCnt    <= next_bitCnt;
            startSeen <= startTog;
            sdaOe     <= next_sdaOe;
            // R10 store bit
            // word is held until the next frame, so the other side
            // may read it at leisure once the toggle has crossed
            if (wordDone && !startNow) begin
                // the store bit arrives last, after the seven code bits
                linkWord   <= vdc_pkg::vdc_word_s'(
                    {shiftReg[0], shiftReg[7:1]});
                wordToggle <= ~wordToggle;
            end
        end
    end

endmodule // vdc_link

// file: rtl/vdc_top.sv
// dac setting register with an eeprom shadow behind a two-wire slave
// assumes clk_sys at 50 MHz, rst_n as the power-on reset, and the bus
// clock supplied by the master on scl or, when unprotected, on sclSw
`timescale 1ns/1ps

// Notes on behaviour
// R01: dac current is (setting code + 1) / 128 of full scale
// R02: setting is a 7-bit volatile register driving the dac directly
// R03: a store command copies the setting code into the eeprom cell
// R04: after power-on the eeprom content is loaded into the setting
// R05: the eeprom may be rewritten any later time unless protected
// R06: switched clock input is the bus clock only while wpN is high
// R07: wpP always shows the inverse of the wpN input (here wpP lags wpN by three clk_sys cycles through the synchroniser)
// R08: the master clocks the bus no faster than 400 kHz
// R09: only slave address byte 9E is answered
// R10: bit after the seven code bits picks volatile-only or store
// R11: while wpN is low or floating, stores become volatile writes
// R12: setting stays unchanged while the eeprom is programming
// R13: store bit one asks for eeprom programming, zero does not
module vdc_top #(
    parameter int STARTUP_CYC = vdc_pkg::STARTUP_CYC,
    parameter int PROG_CYC    = vdc_pkg::PROG_CYC
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic                          scl,
    input  wire logic                          sclSw,
    input  wire logic                          sdaIn,
    input  wire logic                          wpN,
    output logic                               sdaOut,
    output logic                               sdaOe,
    output logic                               wpP,
    output logic [vdc_pkg::CODE_W-1:0]         dacCode,
    output logic [vdc_pkg::STEPS_W-1:0]        dacSteps,
    output logic                               progBusy,
    output logic                               loadDone,
    output logic                               storeRefused,
    output logic                               writeDropped
);

    // ------------------------------------------------------------------
    // bus side, running on the bus clock
    // ------------------------------------------------------------------
    vdc_pkg::vdc_word_s linkWord;
    logic               wordToggle;
    logic               linkSdaOe;

    // R08 bus rate
    // the falling-edge framing relies on at least a few system clocks
    // between a finished frame and the next one
    vdc_link u_link (
        .rst_n      (rst_n),
        .scl        (scl),
        .sclSw      (sclSw),
        .sdaIn      (sdaIn),
        .wpN        (wpN),
        .sdaOe      (linkSdaOe),
        .linkWord   (linkWord),
        .wordToggle (wordToggle)
    );

    // acknowledge is driven from the bus-clock flop itself; sdaOut is
    // a constant-low flop so the pin only ever pulls down
    assign sdaOe = linkSdaOe;

    // ------------------------------------------------------------------
    // synchronisers into the system clock
    // ------------------------------------------------------------------
    logic wpMeta;
    logic wpSync;
    logic togMeta;
    logic togSync;
    logic togSeen;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wpMeta  <= 1'b0;
            wpSync  <= 1'b0;
            togMeta <= 1'b0;
            togSync <= 1'b0;
            togSeen <= 1'b0;
        end else begin
            wpMeta  <= wpN;
            wpSync  <= wpMeta;
            togMeta <= wordToggle;
            togSync <= togMeta;
            togSeen <= togSync;
        end
    end

    // ------------------------------------------------------------------
    // decode of an arriving word
    // ------------------------------------------------------------------
    wire logic                        wordEvent;
    wire logic                        storeAsk;
    wire logic                        storeOk;
    wire logic [vdc_pkg::CODE_W-1:0]  wordCode;

    // a toggle edge means a whole frame landed; linkWord has been
    // stable since it changed together with the toggle
    assign wordEvent = togSync ^ togSeen;
    assign wordCode  = linkWord.code;
    // R13 store bit meaning
    assign storeAsk  = linkWord.store;
    // R11 protect gate
    assign storeOk   = storeAsk && wpSync;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    localparam logic [vdc_pkg::TIMER_W-1:0] LOAD_LAST =
        vdc_pkg::TIMER_W'(STARTUP_CYC - 1);
    localparam logic [vdc_pkg::TIMER_W-1:0] PROG_LAST =
        vdc_pkg::TIMER_W'(PROG_CYC - 1);

    vdc_pkg::vdc_state_e              state;
    vdc_pkg::vdc_state_e              next_state;
    logic [vdc_pkg::TIMER_W-1:0]      timer;
    logic [vdc_pkg::TIMER_W-1:0]      next_timer;
    logic [vdc_pkg::CODE_W-1:0]       progData;
    logic [vdc_pkg::CODE_W-1:0]       next_progData;
    logic [vdc_pkg::CODE_W-1:0]       setting;
    logic [vdc_pkg::CODE_W-1:0]       next_setting;
    logic                             loadNow;
    logic                             eeWrite;
    logic                             acceptWord;
    logic                             dropWord;
    logic                             refuseStore;
    logic [vdc_pkg::CODE_W-1:0]       eeCell = vdc_pkg::EE_ERASED;

    wire logic loadTimeUp;
    wire logic progTimeUp;

    assign loadTimeUp = (timer == LOAD_LAST);
    assign progTimeUp = (timer == PROG_LAST);

    always_comb begin
        next_state    = state;
        next_timer    = timer + 1'b1;
        next_progData = progData;
        next_setting  = setting;
        loadNow       = 1'b0;
        eeWrite       = 1'b0;
        acceptWord    = 1'b0;
        dropWord      = 1'b0;
        refuseStore   = 1'b0;
        case (state)
            vdc_pkg::VDC_LOAD: begin
                dropWord = wordEvent;
                if (loadTimeUp) begin
                    // R04 power-on load
                    loadNow      = 1'b1;
                    next_setting = eeCell;
                    next_timer   = '0;
                    next_state   = vdc_pkg::VDC_RUN;
                end
            end
            vdc_pkg::VDC_RUN: begin
                next_timer = '0;
                if (wordEvent) begin
                    acceptWord = 1'b1;
                    // R02 volatile write
                    next_setting = wordCode;
                    refuseStore  = storeAsk && !storeOk;
                    // R03 start store
                    // R05 rewritable any time
                    if (storeOk) begin
                        next_progData = wordCode;
                        next_state    = vdc_pkg::VDC_PROG;
                    end
                end
            end
            vdc_pkg::VDC_PROG: begin
                // R12 hold during programming
                dropWord = wordEvent;
                if (progTimeUp) begin
                    eeWrite    = 1'b1;
                    next_timer = '0;
                    next_state = vdc_pkg::VDC_RUN;
                end
            end
            default: begin
                next_timer = '0;
                next_state = vdc_pkg::VDC_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state    <= vdc_pkg::VDC_LOAD;
            timer    <= '0;
            progData <= vdc_pkg::SETTING_RST;
            setting  <= vdc_pkg::SETTING_RST;
        end else begin
            state    <= next_state;
            timer    <= next_timer;
            progData <= next_progData;
            setting  <= next_setting;
        end
    end

    // ------------------------------------------------------------------
    // nonvolatile cell
    // ------------------------------------------------------------------
    // no reset on purpose: the content must survive power-on reset
    always_ff @(posedge clk_sys) begin
        // R03 cell update
        if (eeWrite) begin
            eeCell <= progData;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    wire logic [vdc_pkg::STEPS_W-1:0] stepsNext;

    // R01 fraction of full scale
    // code 0 gives one step, code 127 gives all 128 steps
    assign stepsNext = {1'b0, next_setting} + 8'h01;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sdaOut       <= 1'b0;
            wpP          <= 1'b1;
            dacCode      <= vdc_pkg::SETTING_RST;
            dacSteps     <= 8'h01;
            progBusy     <= 1'b0;
            loadDone     <= 1'b0;
            storeRefused <= 1'b0;
            writeDropped <= 1'b0;
        end else begin
            sdaOut       <= 1'b0;
            // R07 inverted protect
            wpP          <= ~wpSync;
            // R02 dac drive
            dacCode      <= next_setting;
            dacSteps     <= stepsNext;
            progBusy     <= (next_state == vdc_pkg::VDC_PROG);
            loadDone     <= loadDone | loadNow;
            storeRefused <= refuseStore;
            writeDropped <= dropWord;
        end
    end

    // unused in logic, kept for readability of the accept path
    wire logic unusedAccept;
    assign unusedAccept = acceptWord;

endmodule // vdc_top

// file: test/vdc_top_properties.sv
// concurrent checks on the ports of vdc_top, clk_sys domain only
// assumes the bench holds wpN steady around every store
`timescale 1ns/1ps

module vdc_top_properties #(
    parameter int STARTUP_CYC = 20,
    parameter int PROG_CYC    = 50
) (
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    input wire logic                        wpN,
    input wire logic                        wpP,
    input wire logic [vdc_pkg::CODE_W-1:0]  dacCode,
    input wire logic [vdc_pkg::STEPS_W-1:0] dacSteps,
    input wire logic                        progBusy,
    input wire logic                        loadDone,
    input wire logic                        storeRefused,
    input wire logic                        writeDropped
);
    // --------------------------------------------------------------
    // helper counters
    // --------------------------------------------------------------
    int upCnt;
    int busyCnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            upCnt   <= 0;
            busyCnt <= 0;
        end else begin
            upCnt   <= upCnt + 1;
            busyCnt <= progBusy ? busyCnt + 1 : 0;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    a_prot_inverse: assert property (
        $stable(wpN) [*6] |-> wpP == !wpN)
        else $error("wpP is not the inverse of wpN");
    a_steps_match: assert property (
        dacSteps == {1'b0, dacCode} + 8'h01)
        else $error("dacSteps is not dacCode plus one");
    a_load_time: assert property (
        $rose(loadDone) |-> upCnt >= STARTUP_CYC - 1
                            && upCnt <= STARTUP_CYC + 2)
        else $error("load finished at the wrong time");
    a_load_sticky: assert property (
        loadDone |=> loadDone)
        else $error("loadDone fell");
    a_busy_length: assert property (
        $fell(progBusy) |-> busyCnt >= PROG_CYC - 1
                            && busyCnt <= PROG_CYC + 1)
        else $error("programming time is wrong");
    a_busy_freeze: assert property (
        progBusy && $past(progBusy) |-> $stable(dacCode))
        else $error("setting changed while programming");
    a_busy_needs_wp: assert property (
        $rose(progBusy) |-> !wpP)
        else $error("programming started while protected");
    a_refuse_volatile: assert property (
        storeRefused |-> !progBusy ##1 !progBusy)
        else $error("refused store started programming");
    a_drop_keeps: assert property (
        writeDropped |=> $stable(dacCode) [*2])
        else $error("dropped word changed the setting");
    a_busy_after_load: assert property (
        progBusy |-> loadDone)
        else $error("programming before the power-on load");
endmodule // vdc_top_properties

bind vdc_top vdc_top_properties #(
    .STARTUP_CYC(STARTUP_CYC),
    .PROG_CYC   (PROG_CYC)
) u_props (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .wpN         (wpN),
    .wpP         (wpP),
    .dacCode     (dacCode),
    .dacSteps    (dacSteps),
    .progBusy    (progBusy),
    .loadDone    (loadDone),
    .storeRefused(storeRefused),
    .writeDropped(writeDropped)
);

// file: test/vdc_bus_master.sv
// two-wire bus master model sending write frames at an 80 ns bit time
// assumes a pull-up on the data line; the slave only pulls it low
`timescale 1ns/1ps

module vdc_bus_master (
    output logic      scl,
    output logic      sclSw,
    output logic      sdaM,
    input  wire logic sda
);
    logic onSw  = 1'b0;
    logic clkLv = 1'b1;

    initial sdaM = 1'b1;
    // idle clock pin rests high so the wired-and follows the other
    assign scl   = onSw ? 1'b1 : clkLv;
    assign sclSw = onSw ? clkLv : 1'b1;

    // bit time: one bit per link clock period
    task automatic put_bit(input logic b);
        clkLv = 1'b0;
        #10 sdaM = b;
        #30 clkLv = 1'b1;
        #40;
    endtask

    task automatic get_ack(output logic a);
        clkLv = 1'b0;
        #10 sdaM = 1'b1;
        #30 clkLv = 1'b1;
        #20 a = !sda;
        #20;
    endtask

    task automatic frame(input logic sw, input logic [7:0] adr,
                         input logic [7:0] dat, output logic [1:0] acks);
        #7 onSw = sw;
        #20 sdaM = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) put_bit(adr[i]);
        get_ack(acks[1]);
        for (int i = 7; i >= 0; i--) put_bit(dat[i]);
        get_ack(acks[0]);
        clkLv = 1'b0;
        #10 sdaM = 1'b0;
        #30 clkLv = 1'b1;
        #20 sdaM = 1'b1;
        #40 onSw = 1'b0;
    endtask
endmodule // vdc_bus_master

// file: test/test_vdc_top.sv
// self-checking bench for vdc_top with a reference model
// assumes vdc_bus_master and the bound checker are compiled first
`timescale 1ns/1ps

module test_vdc_top;
    localparam int SU_CYC = 20;
    localparam int PR_CYC = 200;
    logic                        clk_sys = 1'b0;
    logic                        rst_n;
    logic                        wpN     = 1'b0;
    logic                        scl, sclSw, sdaM, sdaOut, sdaOe, wpP;
    logic                        progBusy, loadDone;
    logic                        storeRefused, writeDropped, sdaWire;
    logic [vdc_pkg::CODE_W-1:0]  dacCode;
    logic [vdc_pkg::STEPS_W-1:0] dacSteps;
    logic [1:0]                  acks;
    int mismatches = 0, num_checks = 0, seed = 79;
    int mCode = 0, mEe = 0, mBusy = 0;
    int refCnt = 0, dropCnt = 0, expRef = 0, expDrop = 0;

    always #10 clk_sys = ~clk_sys;
    // pulled-up data line, low when either side drives low
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) & sdaM;
    always @(posedge clk_sys) begin
        if (storeRefused === 1'b1) refCnt++;
        if (writeDropped === 1'b1) dropCnt++;
    end

    vdc_top #(.STARTUP_CYC(SU_CYC), .PROG_CYC(PR_CYC)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sclSw(sclSw),
        .sdaIn(sdaWire), .wpN(wpN), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .wpP(wpP), .dacCode(dacCode), .dacSteps(dacSteps),
        .progBusy(progBusy), .loadDone(loadDone),
        .storeRefused(storeRefused), .writeDropped(writeDropped));
    vdc_bus_master u_master (
        .scl(scl), .sclSw(sclSw), .sdaM(sdaM), .sda(sdaWire));

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // busy=1 waits for programming to end, else for the load
    task automatic wait_for(input bit busy);
        for (int n = 0; n < PR_CYC + SU_CYC + 50; n++) begin
            @(posedge clk_sys);
            if (busy ? progBusy === 1'b0 : loadDone === 1'b1) begin
                mBusy = 0;
                return;
            end
        end
        check("wait bound", 8'h00, 8'h01);
        end_of_test();
    endtask

    task automatic power_up();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_for(1'b0);
        repeat (2) @(posedge clk_sys);
        mCode = mEe;
        check("dacCode after load", mEe[7:0], {1'b0, dacCode});
    endtask

    task automatic set_wp(input logic v);
        @(posedge clk_sys);
        wpN <= v;
        repeat (8) @(posedge clk_sys);
        check("wpP", {7'h00, ~v}, {7'h00, wpP});
    endtask

    task automatic send(input logic sw, input logic [7:0] adr,
                        input logic [6:0] code, input logic st);
        bit acc;
        acc = adr == vdc_pkg::ADDR_BYTE && (!sw || wpN);
        @(posedge clk_sys);
        u_master.frame(sw, adr, {code, st}, acks);
        repeat (6) @(posedge clk_sys);
        if (acc && mBusy != 0) expDrop++;
        else if (acc) begin
            mCode = code;
            if (st && wpN) begin
                mEe   = code;
                mBusy = 1;
            end else if (st) expRef++;
        end
        check("acks", {6'h00, acc, acc}, {6'h00, acks});
        check("dacCode", mCode[7:0], {1'b0, dacCode});
        check("dacSteps", mCode[7:0] + 8'h01, dacSteps);
        check("progBusy", {7'h00, mBusy[0]}, {7'h00, progBusy});
        check("refusals", expRef[7:0], refCnt[7:0]);
        check("drops", expDrop[7:0], dropCnt[7:0]);
    endtask

    initial begin
        logic [6:0] c;
        // an unknown-to-low step gives the bus-clock flops a reset edge
        rst_n <= 1'b0;
        power_up();
        set_wp(1'b0);
        send(1'b0, 8'h9E, 7'h00, 1'b1);
        send(1'b0, 8'h9E, 7'h7F, 1'b0);
        for (int i = 0; i < 4; i++) begin
            c = 7'($random(seed));
            send(1'b0, 8'h9E, c, i[0]);
        end
        send(1'b0, 8'h9C, 7'h15, 1'b0);
        send(1'b0, 8'h9F, 7'h2A, 1'b0);
        send(1'b1, 8'h9E, 7'h33, 1'b0);
        set_wp(1'b1);
        send(1'b1, 8'h9E, 7'h4C, 1'b0);
        c = 7'($random(seed));
        send(1'b0, 8'h9E, c, 1'b1);
        send(1'b0, 8'h9E, ~c, 1'b1);
        wait_for(1'b1);
        power_up();
        send(1'b0, 8'h9E, 7'h01, 1'b1);
        wait_for(1'b1);
        set_wp(1'b0);
        power_up();
        end_of_test();
    end
endmodule // test_vdc_top
